// ---- hw/bcc_pkg.sv ----
// Constants and types shared by the battery charge controller
package bcc_pkg;
  // Overview of operation
  // - Full charge begins only above upper minimum threshold, ends below lower one.
  // - Software writes a 4-bit charge current target for constant-current charging.
  // - Software writes a 6-bit charge voltage target for constant-voltage charging.
  // - A 3-bit field selects the end-of-charge current.
  // - A 4-bit field selects the largest current drawn from the source.
  // - A 3-bit field selects the source voltage treated as collapse.
  // - Charge watchdog period programmable up to 127 s, 32 s after reset.
  // - Source collapse in full charge lowers the charge current step by step.
  // - With termination on, low current in constant-voltage mode stops full charging.
  // - Source seen above precharge maximum: enable, gate, start system, record cause.
  // - Source seen between thresholds: charge and start the system at once.
  // - Source seen below upper minimum: charge, start system once battery rises.
  // - Source attached while system powered: interrupt only, no startup action.
  // - Gated charging resumes by itself once the gating cause is gone.
  // - After termination stay stopped until source reconnects or software resumes.
  // - Source attach and detach, upper threshold rise, lower threshold fall, termination and watchdog expiry raise interrupts, each maskable.
  // - Hardware runs startup charging until software writes watchdog, charge current or charge voltage set points.
  // - Hardware mode uses nonvolatile watchdog period, full charge the register.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_S;
  localparam int unsigned STEP_MS = 1;
  localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  localparam logic [6:0] WD_MAX_S = 7'h7F;
  localparam logic [6:0] WD_RST_S = 7'h20;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_ICHRG = 6'h04;
  localparam logic [5:0] OFS_VREG = 6'h08;
  localparam logic [5:0] OFS_ITERM = 6'h0C;
  localparam logic [5:0] OFS_ILIM = 6'h10;
  localparam logic [5:0] OFS_COLL = 6'h14;
  localparam logic [5:0] OFS_WDOG = 6'h18;
  localparam logic [5:0] OFS_STAT = 6'h1C;
  localparam logic [5:0] OFS_IRQ_ST = 6'h20;
  localparam logic [5:0] OFS_IRQ_MSK = 6'h24;
  localparam logic [5:0] OFS_CAUSE = 6'h28;
  // Reset values
  localparam logic [3:0] RST_ICHRG = 4'h0;
  localparam logic [5:0] RST_VREG = 6'h00;
  localparam logic [2:0] RST_ITERM = 3'h0;
  localparam logic [3:0] RST_ILIM = 4'h0;
  localparam logic [2:0] RST_COLL = 3'h0;
  localparam logic RST_TERM_EN = 1'h1;
  // Control register bits
  localparam int unsigned CTRL_RESUME = 0;
  localparam int unsigned CTRL_TERM_EN = 1;
  // Comparator vector positions
  localparam int unsigned NCMP = 9;
  localparam int unsigned C_VBUS = 0;
  localparam int unsigned C_EXT = 1;
  localparam int unsigned C_HI = 2;
  localparam int unsigned C_LO = 3;
  localparam int unsigned C_PRCH = 4;
  localparam int unsigned C_COLL = 5;
  localparam int unsigned C_CV = 6;
  localparam int unsigned C_TERM = 7;
  localparam int unsigned C_PWR = 8;
  // Interrupt status bits
  localparam int unsigned NIRQ = 6;
  localparam int unsigned I_ATT = 0;
  localparam int unsigned I_DET = 1;
  localparam int unsigned I_TERM = 2;
  localparam int unsigned I_WDOG = 3;
  localparam int unsigned I_HI = 4;
  localparam int unsigned I_LO = 5;
  // Startup cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_GATED = 2'h1;
  localparam logic [1:0] CAUSE_DIRECT = 2'h2;
  localparam logic [1:0] CAUSE_DEFER = 2'h3;
  typedef enum logic [1:0] {CS_IDLE, CS_HW, CS_FULL, CS_DONE} bcc_state_t;
endpackage

// ---- hw/bcc_top.sv ----
// Battery charge controller: state machine, watchdog, registers, interrupts
`timescale 1ns/1ns
module bcc_top
  import bcc_pkg::*;
#(
  parameter int unsigned SEC_CYC = SEC_CYCLES,
  parameter int unsigned STEP_CYC = STEP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog comparators and status inputs
  input wire logic vbus_det,
  input wire logic external_charger_supply,
  input wire logic battery_min_upper_threshold,
  input wire logic battery_min_lower_threshold,
  input wire logic precharge_max_voltage,
  input wire logic source_collapsed,
  input wire logic cv_mode,
  input wire logic current_below_term,
  input wire logic system_powered,
  // Nonvolatile watchdog default
  input wire logic [6:0] nv_wd_period,
  // Charger control
  output logic charge_enable,
  output logic charge_gated,
  output logic system_startup,
  output logic [3:0] charge_current_setpoint,
  output logic [5:0] charge_voltage_setpoint,
  output logic [2:0] end_of_charge_current_setpoint,
  output logic [3:0] input_current_limit,
  output logic [2:0] input_collapse_voltage,
  // Interrupt
  output logic irq
);

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [NCMP-1:0] raw, s1_r, s2_r, s3_r, cmp_r, cmp_d_r, rise, fall;
  logic wait_r, wr, term_en_r, resume, takeover, wd_wr;
  logic [31:0] rdata_r;
  logic [3:0] ich_r, ilim_r, cur_r;
  logic [5:0] vreg_r;
  logic [2:0] iterm_r, coll_r;
  logic [6:0] wd_r, nv_r, wd_cnt_r;
  logic nv_ok_r;
  logic [NIRQ-1:0] ist_r, imsk_r, iev;
  logic [1:0] cause_r;
  bcc_state_t st_r, st_d_r;
  logic src, src_d, attach, detach, pend_r, start_r, chg_r, gate_r, irq_r;
  logic [16:0] step_cnt_r;
  logic step_tick;
  logic [26:0] sec_cnt_r;
  logic sec_tick, wd_load, wd_exp_r, term_hit, wd_wr_d_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Three-stage synchroniser; accept a level once stages two and three agree
  assign raw = {system_powered, current_below_term, cv_mode, source_collapsed,
                precharge_max_voltage, battery_min_lower_threshold,
                battery_min_upper_threshold, external_charger_supply, vbus_det};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      cmp_r <= '0;
      cmp_d_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      cmp_r <= (cmp_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
      cmp_d_r <= cmp_r;
    end
  end
  assign rise = cmp_r & ~cmp_d_r;
  assign fall = ~cmp_r & cmp_d_r;
  assign src = cmp_r[C_VBUS] | cmp_r[C_EXT];
  assign src_d = cmp_d_r[C_VBUS] | cmp_d_r[C_EXT];
  assign attach = src & ~src_d;
  assign detach = ~src & src_d;

  // Bus handshake: one wait cycle, then a single low cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 1'h1;
    end else begin
      wait_r <= !(wait_r && (avs_read || avs_write));
    end
  end
  assign wr = avs_write && !wait_r;
  assign resume = wr && hit(avs_address, OFS_CTRL) && avs_writedata[CTRL_RESUME];
  assign wd_wr = wr && hit(avs_address, OFS_WDOG);
  assign takeover = wd_wr || (wr && (hit(avs_address, OFS_ICHRG) ||
                    hit(avs_address, OFS_VREG)));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else if (avs_read && wait_r) begin
      unique case (avs_address)
        OFS_CTRL: rdata_r <= {30'h0, term_en_r, 1'h0};
        OFS_ICHRG: rdata_r <= {28'h0, ich_r};
        OFS_VREG: rdata_r <= {26'h0, vreg_r};
        OFS_ITERM: rdata_r <= {29'h0, iterm_r};
        OFS_ILIM: rdata_r <= {28'h0, ilim_r};
        OFS_COLL: rdata_r <= {29'h0, coll_r};
        OFS_WDOG: rdata_r <= {25'h0, wd_r};
        OFS_STAT: rdata_r <= {11'h0, wd_cnt_r, cmp_r, gate_r, chg_r, pend_r, st_r};
        OFS_IRQ_ST: rdata_r <= {26'h0, ist_r};
        OFS_IRQ_MSK: rdata_r <= {26'h0, imsk_r};
        OFS_CAUSE: rdata_r <= {30'h0, cause_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  // Set points and control written by software
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      term_en_r <= RST_TERM_EN;
      ich_r <= RST_ICHRG;
      vreg_r <= RST_VREG;
      iterm_r <= RST_ITERM;
      ilim_r <= RST_ILIM;
      coll_r <= RST_COLL;
      wd_r <= WD_RST_S;
      imsk_r <= '0;
    end else if (wr) begin
      unique case (avs_address)
        OFS_CTRL: term_en_r <= avs_writedata[CTRL_TERM_EN];
        OFS_ICHRG: ich_r <= avs_writedata[3:0];
        OFS_VREG: vreg_r <= avs_writedata[5:0];
        OFS_ITERM: iterm_r <= avs_writedata[2:0];
        OFS_ILIM: ilim_r <= avs_writedata[3:0];
        OFS_COLL: coll_r <= avs_writedata[2:0];
        OFS_WDOG: wd_r <= (avs_writedata[6:0] > WD_MAX_S) ? WD_MAX_S : avs_writedata[6:0];
        OFS_IRQ_MSK: imsk_r <= avs_writedata[NIRQ-1:0];
        default: ;
      endcase
    end
  end

  // Nonvolatile watchdog default caught after reset release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_ok_r <= 1'h0;
      nv_r <= WD_RST_S;
    end else if (!nv_ok_r) begin
      nv_ok_r <= 1'h1;
      nv_r <= nv_wd_period;
    end
  end

  // Charge state machine
  assign term_hit = term_en_r && cmp_r[C_CV] && cmp_r[C_TERM];
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= CS_IDLE;
    end else if (detach && !src) begin
      st_r <= CS_IDLE;
    end else begin
      unique case (st_r)
        CS_IDLE: begin
          if (attach && !cmp_r[C_PWR]) st_r <= CS_HW;
          else if (resume && src && cmp_r[C_HI]) st_r <= CS_FULL;
        end
        CS_HW: begin
          if (takeover && cmp_r[C_HI]) st_r <= CS_FULL;
        end
        CS_FULL: begin
          if (!cmp_r[C_LO]) st_r <= CS_IDLE;
          else if (term_hit) st_r <= CS_DONE;
          else if (wd_exp_r) st_r <= CS_HW;
        end
        CS_DONE: begin
          if (resume && cmp_r[C_HI]) st_r <= CS_FULL;
        end
      endcase
    end
  end

  // Startup request, cause and deferred start
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_r <= 1'h0;
      pend_r <= 1'h0;
      cause_r <= CAUSE_NONE;
    end else begin
      start_r <= 1'h0;
      if (attach && st_r == CS_IDLE && !cmp_r[C_PWR]) begin
        if (cmp_r[C_HI]) start_r <= 1'h1;
        else pend_r <= 1'h1;
        if (cmp_r[C_PRCH]) cause_r <= CAUSE_GATED;
        else if (cmp_r[C_HI]) cause_r <= CAUSE_DIRECT;
        else cause_r <= CAUSE_DEFER;
      end else if (pend_r && (detach || cmp_r[C_PWR])) begin
        pend_r <= 1'h0;
      end else if (pend_r && cmp_r[C_HI]) begin
        pend_r <= 1'h0;
        start_r <= 1'h1;
      end
    end
  end

  // Charge enable and gating levels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_r <= 1'h0;
      gate_r <= 1'h0;
      st_d_r <= CS_IDLE;
    end else begin
      chg_r <= (st_r == CS_HW) || (st_r == CS_FULL);
      gate_r <= (st_r == CS_HW) && cmp_r[C_PRCH];
      st_d_r <= st_r;
    end
  end

  // Collapse current reduction, one step per tick
  assign step_tick = (step_cnt_r == 17'(STEP_CYC - 1));
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt_r <= '0;
      cur_r <= RST_ICHRG;
    end else begin
      step_cnt_r <= step_tick ? '0 : step_cnt_r + 17'h1;
      if (st_r != CS_FULL || cur_r > ich_r) begin
        cur_r <= ich_r;
      end else if (step_tick) begin
        if (cmp_r[C_COLL] && cur_r != 4'h0) cur_r <= cur_r - 4'h1;
        else if (!cmp_r[C_COLL] && cur_r < ich_r) cur_r <= cur_r + 4'h1;
      end
    end
  end

  // Charge watchdog in seconds
  assign sec_tick = (sec_cnt_r == 27'(SEC_CYC - 1));
  // Reload a cycle after a period write so the new period is taken
  assign wd_load = (st_r != st_d_r) || wd_wr_d_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_cnt_r <= '0;
      wd_cnt_r <= WD_RST_S;
      wd_exp_r <= 1'h0;
      wd_wr_d_r <= 1'h0;
    end else begin
      wd_exp_r <= 1'h0;
      wd_wr_d_r <= wd_wr;
      if (wd_load) begin
        sec_cnt_r <= '0;
        wd_cnt_r <= (st_r == CS_FULL) ? wd_r : nv_r;
      end else if (st_r == CS_HW || st_r == CS_FULL) begin
        sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 27'h1;
        if (sec_tick && wd_cnt_r != 7'h0) begin
          wd_cnt_r <= wd_cnt_r - 7'h1;
          wd_exp_r <= (wd_cnt_r == 7'h1);
        end
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_comb begin
    iev = '0;
    iev[I_ATT] = attach;
    iev[I_DET] = detach;
    iev[I_TERM] = (st_r == CS_FULL) && term_hit && cmp_r[C_LO];
    iev[I_WDOG] = wd_exp_r;
    iev[I_HI] = rise[C_HI];
    iev[I_LO] = fall[C_LO];
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ist_r <= '0;
      irq_r <= 1'h0;
    end else begin
      if (wr && hit(avs_address, OFS_IRQ_ST)) ist_r <= (ist_r & ~avs_writedata[NIRQ-1:0]) | iev;
      else ist_r <= ist_r | iev;
      irq_r <= |(ist_r & ~imsk_r);
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign charge_enable = chg_r;
  assign charge_gated = gate_r;
  assign system_startup = start_r;
  assign charge_current_setpoint = cur_r;
  assign charge_voltage_setpoint = vreg_r;
  assign end_of_charge_current_setpoint = iterm_r;
  assign input_current_limit = ilim_r;
  assign input_collapse_voltage = coll_r;
  assign irq = irq_r;

  // Checks
  sequence s_gated_start;
    start_r && cause_r == CAUSE_GATED && st_r == CS_HW;
  endsequence
  sequence s_gate_on;
    chg_r && gate_r;
  endsequence

  full_entry_a: assert property ($rose(st_r == CS_FULL) |-> $past(cmp_r[C_HI]))
    else $error("full charge entered below upper threshold");
  full_exit_a: assert property (st_r == CS_FULL && !cmp_r[C_LO] |=> st_r == CS_IDLE)
    else $error("full charge kept below lower threshold");
  term_setpt_a: assert property (wr && hit(avs_address, OFS_ITERM) |=> ##1
    end_of_charge_current_setpoint == $past(avs_writedata[2:0], 2))
    else $error("end-of-charge set point not taken");
  wd_hw_load_a: assert property (wd_load && st_r == CS_HW |=> wd_cnt_r == nv_r)
    else $error("hardware watchdog not from nonvolatile period");
  wd_full_load_a: assert property (wd_load && st_r == CS_FULL |=> wd_cnt_r == $past(wd_r))
    else $error("full-charge watchdog not from register period");
  collapse_step_a: assert property (st_r == CS_FULL && cmp_r[C_COLL] && step_tick
    && cur_r != 4'h0 && cur_r <= ich_r |=> cur_r == $past(cur_r) - 4'h1)
    else $error("current not lowered on collapse");
  term_stop_a: assert property (st_r == CS_FULL && cmp_r[C_LO] && term_hit && src
    |=> st_r == CS_DONE ##1 !chg_r)
    else $error("termination did not stop charging");
  gated_start_a: assert property (st_r == CS_IDLE && attach && !cmp_r[C_PWR]
    && cmp_r[C_HI] && cmp_r[C_PRCH] |=> s_gated_start ##1 s_gate_on)
    else $error("gated startup sequence wrong");
  defer_start_a: assert property (pend_r && cmp_r[C_HI] && !detach && !cmp_r[C_PWR]
    |=> start_r && !pend_r)
    else $error("deferred startup missing");
  powered_a: assert property (st_r == CS_IDLE && attach && cmp_r[C_PWR]
    |=> !start_r && st_r == CS_IDLE && ist_r[I_ATT])
    else $error("startup action with system powered");
  done_hold_a: assert property (st_r == CS_DONE && !resume && !detach |=> st_r == CS_DONE)
    else $error("terminated charge restarted alone");
  irq_level_a: assert property ((ist_r & ~imsk_r) != '0 |=> irq)
    else $error("unmasked status without interrupt");
  takeover_a: assert property (st_r == CS_HW && takeover && cmp_r[C_HI] && !detach
    |=> st_r == CS_FULL)
    else $error("software takeover ignored");

endmodule

// ---- verif/bcc_src_model.sv ----
// Charging source and battery model feeding the comparator inputs
`timescale 1ns/1ns
module bcc_src_model (
  // Bench commands
  input wire logic usb_on,
  input wire logic ext_on,
  input wire logic [1:0] bat_lvl,
  input wire logic sag,
  input wire logic taper,
  // Comparator levels
  output logic vbus_det,
  output logic external_charger_supply,
  output logic battery_min_upper_threshold,
  output logic battery_min_lower_threshold,
  output logic precharge_max_voltage,
  output logic source_collapsed,
  output logic cv_mode,
  output logic current_below_term
);
  logic src;
  assign src = usb_on | ext_on;
  assign vbus_det = usb_on;
  assign external_charger_supply = ext_on;
  // Thresholds nest: 0 below lower, 1 between minimums, 2 above upper, 3 above precharge max
  assign battery_min_lower_threshold = bat_lvl >= 2'h1;
  assign battery_min_upper_threshold = bat_lvl >= 2'h2;
  assign precharge_max_voltage = bat_lvl == 2'h3;
  // No sag and no current taper without a source
  assign source_collapsed = src & sag;
  assign cv_mode = src & taper;
  assign current_below_term = src & taper;
endmodule

// ---- verif/tb_battery_charge_controller.sv ----
// Self-checking bench for the battery charge controller
`timescale 1ns/1ns
module tb_battery_charge_controller;
  import bcc_pkg::*;
  localparam int unsigned SEC_T = 20;
  localparam int unsigned STEP_T = 8;
  typedef struct packed {logic wr; logic [5:0] adr; logic [31:0] dat; logic [31:0] exp;} bcc_row_t;
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic usb_on, ext_on, sag, taper, pwr, seen;
  logic [1:0] bat_lvl;
  logic vbus, ext, hi, lo, prch, coll, cv, below;
  logic charge_enable, charge_gated, system_startup;
  logic [3:0] ichg, ilim;
  logic [5:0] vchg;
  logic [2:0] iterm, vcoll;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  bcc_row_t rows [19] = '{
    '{1'b0, OFS_WDOG, 32'h0, 32'h20}, '{1'b0, OFS_CTRL, 32'h0, 32'h2},
    '{1'b0, OFS_ICHRG, 32'h0, 32'h0}, '{1'b1, OFS_ICHRG, 32'hFFFFFFFF, 32'h0},
    '{1'b0, OFS_ICHRG, 32'h0, 32'hF}, '{1'b1, OFS_VREG, 32'hFFFFFFFF, 32'h0},
    '{1'b0, OFS_VREG, 32'h0, 32'h3F}, '{1'b1, OFS_ITERM, 32'hFFFFFFFF, 32'h0},
    '{1'b0, OFS_ITERM, 32'h0, 32'h7}, '{1'b1, OFS_ILIM, 32'hFFFFFFFF, 32'h0},
    '{1'b0, OFS_ILIM, 32'h0, 32'hF}, '{1'b1, OFS_COLL, 32'hFFFFFFFF, 32'h0},
    '{1'b0, OFS_COLL, 32'h0, 32'h7}, '{1'b1, OFS_WDOG, 32'hFF, 32'h0},
    '{1'b0, OFS_WDOG, 32'h0, 32'h7F}, '{1'b1, 6'h2C, 32'h5, 32'h0},
    '{1'b0, 6'h2C, 32'h0, 32'h0}, '{1'b1, OFS_IRQ_MSK, 32'h0, 32'h0},
    '{1'b1, OFS_IRQ_ST, 32'h3F, 32'h0}};

  bcc_src_model u_src (.usb_on(usb_on), .ext_on(ext_on), .bat_lvl(bat_lvl), .sag(sag),
    .taper(taper), .vbus_det(vbus), .external_charger_supply(ext),
    .battery_min_upper_threshold(hi), .battery_min_lower_threshold(lo),
    .precharge_max_voltage(prch), .source_collapsed(coll), .cv_mode(cv),
    .current_below_term(below));

  bcc_top #(.SEC_CYC(SEC_T), .STEP_CYC(STEP_T)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vbus_det(vbus), .external_charger_supply(ext),
    .battery_min_upper_threshold(hi), .battery_min_lower_threshold(lo),
    .precharge_max_voltage(prch), .source_collapsed(coll), .cv_mode(cv),
    .current_below_term(below), .system_powered(pwr), .nv_wd_period(7'h7F),
    .charge_enable(charge_enable), .charge_gated(charge_gated),
    .system_startup(system_startup), .charge_current_setpoint(ichg),
    .charge_voltage_setpoint(vchg), .end_of_charge_current_setpoint(iterm),
    .input_current_limit(ilim), .input_collapse_voltage(vcoll), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One Avalon transfer; read data lands in d; a hang ends at the bench timeout
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic src(input logic u, input logic e, input logic [1:0] l);
    @(posedge sys_clk);
    usb_on <= u;
    ext_on <= e;
    bat_lvl <= l;
  endtask

  task automatic wait_start();
    seen = 1'b0;
    repeat (12) begin
      @(posedge sys_clk);
      if (system_startup === 1'b1) seen = 1'b1;
    end
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    arst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {usb_on, ext_on, sag, taper, pwr} = '0;
    bat_lvl = 2'h3;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    step(1);
    chk(32'({charge_enable, charge_gated, irq, avs_waitrequest}), 32'h1);
    for (int i = 0; i < 19; i++) begin
      bus(rows[i].wr, rows[i].adr, rows[i].dat);
      if (!rows[i].wr) chk(d, rows[i].exp);
    end
    chk(32'({ichg, vchg, iterm, ilim, vcoll}), 32'hFFFFF);
    // Attach above precharge max: gated start
    src(1'b1, 1'b0, 2'h3);
    wait_start();
    chk(32'(seen), 32'h1);
    step(2);
    chk(32'({charge_enable, charge_gated}), 32'h3);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(d, 32'(CAUSE_GATED));
    bus(1'b0, OFS_IRQ_ST, 32'h0);
    chk(32'(d[I_ATT]), 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, OFS_IRQ_MSK, 32'h3F);
    step(3);
    chk(32'(irq), 32'h0);
    bus(1'b1, OFS_IRQ_ST, 32'h3F);
    bus(1'b1, OFS_IRQ_MSK, 32'h0);
    step(3);
    chk(32'(irq), 32'h0);
    src(1'b1, 1'b0, 2'h2);
    step(10);
    chk(32'({charge_enable, charge_gated}), 32'h2);
    bus(1'b1, OFS_ICHRG, 32'h5);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[1:0]), 32'h2);
    sag <= 1'b1;
    step(STEP_T * 3);
    chk(32'(ichg < 4'h5), 32'h1);
    @(posedge sys_clk);
    sag <= 1'b0;
    step(STEP_T * 8);
    chk(32'(ichg), 32'h5);
    @(posedge sys_clk);
    taper <= 1'b1;
    step(10);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'({d[1:0], charge_enable}), 32'h6);
    taper <= 1'b0;
    step(10);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[1:0]), 32'h3);
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[1:0]), 32'h2);
    // Full-charge watchdog of 2 s hands control back to hardware
    bus(1'b1, OFS_WDOG, 32'h2);
    step(SEC_T + 5);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[1:0]), 32'h2);
    step(30);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[1:0]), 32'h1);
    chk(32'(d[20:14] >= 7'h7E), 32'h1);
    bus(1'b0, OFS_IRQ_ST, 32'h0);
    chk(32'(d[I_WDOG]), 32'h1);
    bus(1'b1, OFS_VREG, 32'hA);
    src(1'b1, 1'b0, 2'h0);
    step(10);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'({d[1:0], charge_enable}), 32'h0);
    src(1'b0, 1'b0, 2'h1);
    step(10);
    bus(1'b0, OFS_IRQ_ST, 32'h0);
    chk(32'({d[I_LO], d[I_DET]}), 32'h3);
    // Attach below upper minimum: deferred start
    src(1'b0, 1'b1, 2'h1);
    wait_start();
    chk(32'({seen, charge_enable}), 32'h1);
    bus(1'b1, OFS_VREG, 32'h3);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[2:0]), 32'h5);
    src(1'b0, 1'b1, 2'h2);
    wait_start();
    chk(32'(seen), 32'h1);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(d, 32'(CAUSE_DEFER));
    src(1'b0, 1'b0, 2'h2);
    step(10);
    src(1'b1, 1'b0, 2'h2);
    wait_start();
    chk(32'({seen, charge_gated}), 32'h2);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(d, 32'(CAUSE_DIRECT));
    src(1'b0, 1'b0, 2'h2);
    step(10);
    bus(1'b1, OFS_IRQ_ST, 32'h3F);
    pwr <= 1'b1;
    src(1'b1, 1'b0, 2'h2);
    wait_start();
    chk(32'(seen), 32'h0);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(32'(d[1:0]), 32'h0);
    bus(1'b0, OFS_IRQ_ST, 32'h0);
    chk(32'(d[I_ATT]), 32'h1);
    give_verdict();
  end
endmodule
